// ===== shared/emc_pkg.sv
package emc_pkg;

  // ---------------------------------------------------------------
  // i/o port addresses
  // ---------------------------------------------------------------
  localparam logic [15:0] CTRL_ADDR  = 16'h6872;
  localparam logic [15:0] PTR_ADDR   = 16'hE072;
  localparam logic [15:0] PAGE_ADDR  = 16'hE872;
  localparam logic [15:0] TEST_ADDR  = 16'hA872;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int INC_BIT     = 15;
  localparam int BASE_HI     = 14;
  localparam int BASE_LO     = 13;
  localparam int MAP_HI      = 11;
  localparam int MAP_LO      = 10;
  localparam int RES_EN_BIT  = 7;
  localparam int BOUND_HI    = 6;
  localparam logic [15:0] CTRL_KEEP_MASK = 16'hECFF;
  localparam logic [15:0] CTRL_RESET     = 16'h0000;

  // frame map enable codes
  localparam logic [1:0] MAP_OFF     = 2'b00;
  localparam logic [1:0] MAP_PROG    = 2'b01;
  localparam logic [1:0] MAP_UPPER   = 2'b10;
  localparam logic [1:0] MAP_BOTH    = 2'b11;

  // upper frame start addresses per base select code
  localparam logic [19:0] UPPER_BASE_0 = 20'hC4000;
  localparam logic [19:0] UPPER_BASE_1 = 20'hC8000;
  localparam logic [19:0] UPPER_BASE_2 = 20'hCC000;
  localparam logic [19:0] UPPER_BASE_3 = 20'hD0000;

  // ---------------------------------------------------------------
  // pointer, page registers, test register
  // ---------------------------------------------------------------
  localparam int PTR_W       = 6;
  localparam int DLT_W       = 10;
  localparam int PAGE_COUNT  = 40;
  localparam int PAGE_LAST   = 39;
  localparam int PAGE_CLR_LO = 32;
  localparam logic [15:0] PAGE_KEEP_MASK = 16'h8FFF;
  localparam logic [15:0] PAGE_RESET     = 16'h0000;
  localparam logic [PTR_W-1:0] PTR_RESET = 6'h00;
  localparam logic [PTR_W-1:0] PTR_LAST  = 6'h27;
  localparam int TEST_TRIG_BIT = 8;
  localparam logic        TEST_RESET  = 1'h0;
  localparam logic [15:0] RDATA_RESET = 16'h0000;

  // i/o request carrier
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } emc_io_req_s;

endpackage

// ===== rtl/emc_top.sv
`timescale 1ns/1ps
// Summary of operation
// - auto-increment bit advances pointer per data access
// - base select places eight upper frames
// - control bits 12, 9, 8 ignored
// - map enable 00 disables translation and programming
// - map enable 01 programs only, no translation
// - map enable 10 translates upper frames only
// - map enable 11 translates upper and lower
// - boundary enable uses bits 6-0 as A23-A17
// - pointer indexes page registers, bits 5-0 writable
// - test mode returns delay-line states on 15-6
// - forty page registers, 32-39 cleared at reset
module emc_top (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire emc_pkg::emc_io_req_s  i_io,
  input  wire logic [9:0]            i_delay_line_state,
  output logic [15:0]                o_io_rdata,
  output logic                       o_io_rvalid,
  output logic                       o_translate_upper,
  output logic                       o_translate_lower,
  output logic [19:0]                o_upper_frame_base,
  output logic                       o_reserve_enable,
  output logic [6:0]                 o_reserve_start_boundary
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [15:0]               ctrl_reg;
  logic [emc_pkg::PTR_W-1:0] ptr_reg;
  logic [emc_pkg::PTR_W-1:0] ptr_next;
  logic                      test_trig_reg;
  logic [15:0]               page_mem [emc_pkg::PAGE_COUNT];
  logic [15:0]               rdata_reg;
  logic [15:0]               rdata_next;
  logic                      rvalid_reg;
  logic                      xlate_upper_reg;
  logic                      xlate_lower_reg;
  logic [19:0]               frame_base_reg;
  logic                      reserve_en_reg;
  logic [6:0]                reserve_bound_reg;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire hit_ctrl = (i_io.addr == emc_pkg::CTRL_ADDR);
  wire hit_ptr  = (i_io.addr == emc_pkg::PTR_ADDR);
  wire hit_page = (i_io.addr == emc_pkg::PAGE_ADDR);
  wire hit_test = (i_io.addr == emc_pkg::TEST_ADDR);
  wire any_hit  = hit_ctrl | hit_ptr | hit_page | hit_test;

  // write strobes, one per port
  wire ctrl_wr  = i_io.wr & hit_ctrl;
  wire ptr_wr   = i_io.wr & hit_ptr;
  wire test_wr  = i_io.wr & hit_test;
  wire rd_hit   = i_io.rd & any_hit;

  wire [15:0] ctrl_next = ctrl_wr ? (i_io.wdata & emc_pkg::CTRL_KEEP_MASK)
                                  : ctrl_reg;

  // fields of the stored value, used inside the block
  wire       auto_inc = ctrl_reg[emc_pkg::INC_BIT];
  wire [1:0] frame_map_enable =
    ctrl_reg[emc_pkg::MAP_HI:emc_pkg::MAP_LO];

  // fields of the value being stored, feeding the output registers
  wire [1:0] upper_frame_base_select =
    ctrl_next[emc_pkg::BASE_HI:emc_pkg::BASE_LO];
  wire [1:0] frame_map_enable_next =
    ctrl_next[emc_pkg::MAP_HI:emc_pkg::MAP_LO];
  wire       lower_boundary_enable = ctrl_next[emc_pkg::RES_EN_BIT];
  wire [6:0] reserve_start_boundary = ctrl_next[emc_pkg::BOUND_HI:0];

  wire prog_ok = (frame_map_enable != emc_pkg::MAP_OFF);

  // pointer past the last page register reaches nothing
  wire ptr_valid = (ptr_reg <= emc_pkg::PTR_LAST);
  wire page_wr   = i_io.wr & hit_page & prog_ok & ptr_valid;
  wire page_acc  = (i_io.wr | i_io.rd) & hit_page;

  // new value lands after the access, wraps past last
  assign ptr_next = (ptr_reg >= emc_pkg::PTR_LAST) ? emc_pkg::PTR_RESET
                  : ptr_reg + 6'h01;

  // delay-line bits shown only in test mode
  wire [9:0] delay_line_test_bits =
    test_trig_reg ? i_delay_line_state : 10'h000;

  // ignored control bits read back as zero
  wire [15:0] ctrl_view = ctrl_reg & emc_pkg::CTRL_KEEP_MASK;

  wire [15:0] ptr_view = {delay_line_test_bits, ptr_reg};
  wire [15:0] page_view = ptr_valid ? page_mem[ptr_reg] : 16'h0000;
  wire [15:0] test_view = {7'h00, test_trig_reg, 8'h00};

  // read mux, unmapped ports answer zero
  assign rdata_next = hit_ctrl ? ctrl_view
                    : hit_ptr  ? ptr_view
                    : hit_page ? page_view
                    : hit_test ? test_view
                    : 16'h0000;

  // ---------------------------------------------------------------
  // control, pointer and test registers
  // ---------------------------------------------------------------
  // ignored bits are never stored
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_reg <= emc_pkg::CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // advance only when auto-increment is set
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ptr_reg <= emc_pkg::PTR_RESET;
    end else if (ptr_wr) begin
      ptr_reg <= i_io.wdata[emc_pkg::PTR_W-1:0];
    end else if (page_acc && auto_inc) begin
      ptr_reg <= ptr_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      test_trig_reg <= emc_pkg::TEST_RESET;
    end else if (test_wr) begin
      test_trig_reg <= i_io.wdata[emc_pkg::TEST_TRIG_BIT];
    end
  end

  // ---------------------------------------------------------------
  // page registers
  // ---------------------------------------------------------------
  // only the upper eight are cleared; rest keep contents
  // writes accepted when enable is not 00 and the pointer is at most 39
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int i = emc_pkg::PAGE_CLR_LO; i < emc_pkg::PAGE_COUNT; i++) begin
        page_mem[i] <= emc_pkg::PAGE_RESET;
      end
    end else if (page_wr) begin
      page_mem[ptr_reg] <= i_io.wdata & emc_pkg::PAGE_KEEP_MASK;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  // registered read so the pointer seen is the pre-increment value
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_reg  <= emc_pkg::RDATA_RESET;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= i_io.rd ? rdata_next : rdata_reg;
      rvalid_reg <= rd_hit;
    end
  end

  assign o_io_rdata  = rdata_reg;
  assign o_io_rvalid = rvalid_reg;

  // ---------------------------------------------------------------
  // mapping outputs
  // ---------------------------------------------------------------
  // upper frames for 10 and 11
  wire        xlate_upper_next = frame_map_enable_next[1];
  wire        xlate_lower_next =
    (frame_map_enable_next == emc_pkg::MAP_BOTH);

  wire [19:0] frame_base_next =
      (upper_frame_base_select == 2'h0) ? emc_pkg::UPPER_BASE_0
    : (upper_frame_base_select == 2'h1) ? emc_pkg::UPPER_BASE_1
    : (upper_frame_base_select == 2'h2) ? emc_pkg::UPPER_BASE_2
    : emc_pkg::UPPER_BASE_3;

  // boundary only when enabled
  // the raw field goes out; software applies the 128 KB offset
  wire        reserve_en_next    = lower_boundary_enable;
  wire [6:0]  reserve_bound_next =
    lower_boundary_enable ? reserve_start_boundary : 7'h00;

  // outputs load on the same edge as the control register, so the
  // mapping logic downstream sees registered, glitch-free levels
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      xlate_upper_reg   <= 1'b0;
      xlate_lower_reg   <= 1'b0;
      frame_base_reg    <= emc_pkg::UPPER_BASE_0;
      reserve_en_reg    <= 1'b0;
      reserve_bound_reg <= 7'h00;
    end else begin
      xlate_upper_reg   <= xlate_upper_next;
      xlate_lower_reg   <= xlate_lower_next;
      frame_base_reg    <= frame_base_next;
      reserve_en_reg    <= reserve_en_next;
      reserve_bound_reg <= reserve_bound_next;
    end
  end

  assign o_translate_upper        = xlate_upper_reg;
  assign o_translate_lower        = xlate_lower_reg;
  assign o_upper_frame_base       = frame_base_reg;
  assign o_reserve_enable         = reserve_en_reg;
  assign o_reserve_start_boundary = reserve_bound_reg;

endmodule

// ===== tb/emc_map_monitor.sv
`timescale 1ns/1ps
// ----
// port checker
// ----
module emc_map_monitor (
  input logic                 i_clk,
  input logic                 i_rst,
  input emc_pkg::emc_io_req_s i_io,
  input logic [9:0]           i_delay_line_state,
  input logic [15:0]          o_io_rdata,
  input logic                 o_io_rvalid,
  input logic                 o_translate_upper,
  input logic                 o_translate_lower,
  input logic [19:0]          o_upper_frame_base,
  input logic                 o_reserve_enable,
  input logic [6:0]           o_reserve_start_boundary
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // decoded control writes, control reads and any mapped read
  wire cw = i_io.wr && i_io.addr == emc_pkg::CTRL_ADDR;
  wire cr = i_io.rd && i_io.addr == emc_pkg::CTRL_ADDR;
  wire mr = i_io.rd && (i_io.addr inside {emc_pkg::CTRL_ADDR,
    emc_pkg::PTR_ADDR, emc_pkg::PAGE_ADDR, emc_pkg::TEST_ADDR});
  property p_map; cw |=> o_translate_upper == $past(i_io.wdata[11])
    && o_translate_lower == (&$past(i_io.wdata[11:10])); endproperty
  property p_base; cw |=> o_upper_frame_base ==
    20'hC4000 + {$past(i_io.wdata[14:13]), 14'h0000}; endproperty
  property p_res; cw |=> o_reserve_enable == $past(i_io.wdata[7]);
  endproperty
  property p_bnd; !o_reserve_enable |-> o_reserve_start_boundary == 7'h00;
  endproperty
  property p_ign; cr |=> o_io_rdata[12] == 1'h0 && o_io_rdata[9:8] == 2'h0;
  endproperty
  property p_rv; mr |=> o_io_rvalid; endproperty
  property p_src; o_io_rvalid |-> $past(mr); endproperty
  // read data must hold between reads, software may sample late
  property p_hold; !i_io.rd |=> $stable(o_io_rdata); endproperty
  property p_rst; $fell(i_rst) |-> !o_translate_upper && !o_translate_lower
    && o_upper_frame_base == 20'hC4000 && !o_reserve_enable; endproperty
  a_map: assert property (p_map) else $error("map enable mismatch");
  a_base: assert property (p_base) else $error("frame base wrong");
  a_res: assert property (p_res) else $error("reserve enable wrong");
  a_bnd: assert property (p_bnd) else $error("boundary not zero");
  a_ign: assert property (p_ign) else $error("ignored bits seen");
  a_rv: assert property (p_rv) else $error("read not answered");
  a_src: assert property (p_src) else $error("stray read valid");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_rst: assert property (p_rst) else $error("bad reset state");
  c_both: cover property (o_translate_lower);
  c_rd: cover property (mr ##1 o_io_rvalid);
  c_res: cover property (o_reserve_enable);
endmodule
bind emc_top emc_map_monitor u_mon (.i_clk(i_clk), .i_rst(i_rst),
  .i_io(i_io), .i_delay_line_state(i_delay_line_state),
  .o_io_rdata(o_io_rdata), .o_io_rvalid(o_io_rvalid),
  .o_translate_upper(o_translate_upper),
  .o_translate_lower(o_translate_lower),
  .o_upper_frame_base(o_upper_frame_base),
  .o_reserve_enable(o_reserve_enable),
  .o_reserve_start_boundary(o_reserve_start_boundary));

// ===== tb/expanded_memory_map_control_test.sv
`timescale 1ns/1ps
module expanded_memory_map_control_test;
  logic                 i_clk;
  logic                 i_rst = 1'b1;
  emc_pkg::emc_io_req_s io = '0;
  logic [9:0]           dls = 10'h2A5;
  logic [15:0]          rdata;
  logic                 rv, up, lo, res;
  logic [19:0]          base;
  logic [6:0]           bnd;
  int                   errors = 0, compares = 0, cyc = 0;
  // rows: write, readback, base, boundary, reserve, upper, lower
  logic [61:0] rows [5] = '{
    {16'h1300, 16'h0000, 20'hC4000, 7'h00, 3'h0},
    {16'h2485, 16'h2485, 20'hC8000, 7'h05, 3'h4},
    {16'h4807, 16'h4807, 20'hCC000, 7'h00, 3'h2},
    {16'hEFFF, 16'hECFF, 20'hD0000, 7'h7F, 3'h7},
    {16'h0087, 16'h0087, 20'hC4000, 7'h07, 3'h4}}; // start at 1 MB
  emc_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_io(io),
    .i_delay_line_state(dls), .o_io_rdata(rdata), .o_io_rvalid(rv),
    .o_translate_upper(up), .o_translate_lower(lo),
    .o_upper_frame_base(base), .o_reserve_enable(res),
    .o_reserve_start_boundary(bnd));
  task chk(string n, logic [63:0] e, logic [63:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // one idle edge after each strobe, so no signal is set twice per step
  task wr(logic [15:0] a, logic [15:0] d);
    @(posedge i_clk) io <= '{1'b1, 1'b0, a, d};
    @(posedge i_clk) io <= '0;
  endtask
  task rd(logic [15:0] a, logic [15:0] e);
    @(posedge i_clk) io <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge i_clk) io <= '0;
    #1 chk("read", {a, e, 1'b1}, {a, rdata, rv});
  endtask
  task finish_test();
    if (errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // run is about 100 cycles, so a hang is cut well after this
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      finish_test();
    end
  end
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    #1 chk("reset", {20'hC4000, 10'h000}, {base, bnd, res, up, lo});
    rd(emc_pkg::CTRL_ADDR, 16'h0000);
    wr(emc_pkg::PTR_ADDR, 16'h0020);
    rd(emc_pkg::PAGE_ADDR, 16'h0000);
    wr(emc_pkg::PAGE_ADDR, 16'h8123);
    rd(emc_pkg::PAGE_ADDR, 16'h0000);
    foreach (rows[i]) begin
      wr(emc_pkg::CTRL_ADDR, rows[i][61:46]);
      #1 chk("ctrl", rows[i][29:0], {base, bnd, res, up, lo});
      rd(emc_pkg::CTRL_ADDR, rows[i][45:30]);
    end
    wr(emc_pkg::CTRL_ADDR, 16'h8400);
    wr(emc_pkg::PTR_ADDR, 16'hFFE6);
    rd(emc_pkg::PTR_ADDR, 16'h0026);
    wr(emc_pkg::PAGE_ADDR, 16'hFABC);
    wr(emc_pkg::PAGE_ADDR, 16'h0DEF);
    rd(emc_pkg::PTR_ADDR, 16'h0000);
    wr(emc_pkg::PTR_ADDR, 16'h0026);
    rd(emc_pkg::PAGE_ADDR, 16'h8ABC);
    rd(emc_pkg::PAGE_ADDR, 16'h0DEF);
    wr(emc_pkg::CTRL_ADDR, 16'h0400);
    wr(emc_pkg::PTR_ADDR, 16'h0021);
    rd(emc_pkg::PAGE_ADDR, 16'h0000);
    rd(emc_pkg::PTR_ADDR, 16'h0021);
    @(posedge i_clk) io <= '{1'b0, 1'b1, 16'h1234, 16'h0000};
    @(posedge i_clk) io <= '0;
    #1 chk("unmapped", 1'b0, rv);
    chk("unmapped data", 16'h0000, rdata);
    wr(emc_pkg::TEST_ADDR, 16'h0100);
    rd(emc_pkg::TEST_ADDR, 16'h0100);
    rd(emc_pkg::PTR_ADDR, {10'h2A5, 6'h21});
    @(posedge i_clk) dls <= 10'h15A;
    rd(emc_pkg::PTR_ADDR, {10'h15A, 6'h21});
    wr(emc_pkg::CTRL_ADDR, 16'h68FF);
    #1 chk("ctrl", {20'hD0000, 7'h7F, 3'h6}, {base, bnd, res, up, lo});
    wr(emc_pkg::PTR_ADDR, 16'h0022);
    wr(emc_pkg::PAGE_ADDR, 16'h1234);
    rd(emc_pkg::PAGE_ADDR, 16'h0234);
    wr(emc_pkg::PTR_ADDR, 16'h003F);
    rd(emc_pkg::PAGE_ADDR, 16'h0000);
    // reset in mid-run: state and written upper page registers clear
    @(posedge i_clk) i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    #1 chk("reset", {20'hC4000, 10'h000}, {base, bnd, res, up, lo});
    rd(emc_pkg::PTR_ADDR, 16'h0000);
    wr(emc_pkg::PTR_ADDR, 16'h0022);
    rd(emc_pkg::PAGE_ADDR, 16'h0000);
    finish_test();
  end
endmodule
